/* File: udim_regs.sv */
// Address and mode register bank with suspend, resume and soft-reset sequencing.
// Operation
// RQ1 - 8-bit bus: low byte first
// RQ2 - 16-bit bus: ignore upper lane on bytes
// RQ3 - Select endpoint index before endpoint registers
// RQ4 - Reserved bits unstored, writes ignored
// RQ5 - Address clears on any reset
// RQ6 - Enable clears on resets, sets on bus reset
// RQ7 - Firmware writes address then sends status packet
// RQ8 - New address applies after status acknowledged
// RQ9 - Bits 15..13 mirror strap pins
// RQ10 - Bit 9 gates DMA clock
// RQ11 - Bit 8 shows bus power sense
// RQ12 - Bit 7 keeps clocks; else stop after 2 ms
// RQ13 - Resume toggle: wait 5 ms, drive 10 ms
// RQ14 - Suspend toggle enters suspend
// RQ15 - Soft reset toggle equals hardware reset
// RQ16 - Bit 3 gates interrupt output
// RQ17 - Read in suspend wakes when enabled
// RQ18 - Suspend pin level or 1 ms wake pulse
// RQ19 - Bit 0 connects pull-up, kept over bus reset
`timescale 1ns/1ps
module udim_regs #(
  parameter int SUSP_CLK_CYCLES = udim_pkg::SUSP_CLK_CYC,
  parameter int RESUME_WAIT_CYCLES = udim_pkg::RESUME_WAIT_CYC,
  parameter int RESUME_LEN_CYCLES = udim_pkg::RESUME_LEN_CYC,
  parameter int WAKE_PULSE_CYCLES = udim_pkg::WAKE_PULSE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic busWide16,
  input wire udim_pkg::udim_bus_t busReq,
  output logic [15:0] rdData,
  input wire logic usbBusReset,
  input wire logic statusAcked,
  input wire logic irqPending,
  input wire logic modeSelectPinB,
  input wire logic modeSelectPinA,
  input wire logic busConfigStrap,
  input wire logic busPowerSense,
  output logic [7:0] activeAddr,
  output logic deviceEnabled,
  output logic dmaClockGate,
  output logic oscRunning,
  output logic resumeDrive,
  output logic suspendPin,
  output logic pullupConnect,
  output logic irqOut
);
  // Address register, the address in use for matching, and mode storage.
  logic [7:0] addr_q;
  logic [7:0] addrUse_q;
  logic addrPend_q;
  logic [15:0] mode_q;
  // Strap levels captured after reset release, never under the async reset itself.
  logic [2:0] strap_q;
  logic strapDone_q;
  logic vbus_q;
  // Sequencer state, shared counter and soft-reset request.
  udim_pkg::udim_pstate_t pst_q;
  udim_pkg::udim_pstate_t pst_d;
  logic [udim_pkg::CNT_W-1:0] cnt_q;
  logic [udim_pkg::CNT_W-1:0] cnt_d;
  logic [udim_pkg::CNT_W-1:0] pulse_q;
  logic softRst;

  // On an 8-bit bus the high lane is a second byte access; on 16 bits it is the whole word.
  wire logic [15:0] laneData = busReq.hiLane ? {busReq.wdata[7:0], 8'h00} : {8'h00, busReq.wdata[7:0]};
  wire logic [15:0] wrData = busWide16 ? busReq.wdata : laneData; // see RQ1
  wire logic [15:0] laneMask = busWide16 ? 16'hFFFF : (busReq.hiLane ? 16'hFF00 : 16'h00FF);
  wire logic wrAddr = busReq.wr && (busReq.addr == udim_pkg::ADDR_REG_OFS) && !busReq.hiLane;
  wire logic wrMode = busReq.wr && (busReq.addr == udim_pkg::MODE_REG_OFS);
  wire logic rdAny = busReq.rd && (busReq.addr == udim_pkg::ADDR_REG_OFS || busReq.addr == udim_pkg::MODE_REG_OFS);
  // Only writable bits take new data; reserved and read-only positions stay zero.
  wire logic [15:0] modeMask = laneMask & udim_pkg::MODE_WR_MASK; // see RQ4
  wire logic [15:0] modeNew = (mode_q & ~modeMask) | (wrData & modeMask);
  // A trigger fires on its falling edge, that is, a one followed by a zero written.
  wire logic [15:0] modeFall = mode_q & ~modeNew & {16{wrMode}};
  wire logic resumeTrig = modeFall[udim_pkg::RESUME_BIT]; // see RQ13
  wire logic suspTrig = modeFall[udim_pkg::SUSP_BIT]; // see RQ14
  assign softRst = modeFall[udim_pkg::SRST_BIT]; // see RQ15
  wire logic wakeRead = rdAny && mode_q[udim_pkg::WAKE_RD_BIT] && (pst_q == udim_pkg::PS_SUSP); // see RQ17
  wire logic inSusp = (pst_q == udim_pkg::PS_SUSP_WAIT) || (pst_q == udim_pkg::PS_SUSP);
  // Once the clock stops in suspend the go-suspend bit reads back set; a waking read clears it again,
  // so that a later mode write with that bit low cannot fall and drop the device back into suspend.
  wire logic suspStop = (pst_q == udim_pkg::PS_SUSP_WAIT) && (pst_d == udim_pkg::PS_SUSP)
    && !mode_q[udim_pkg::CLK_ON_BIT]; // see RQ12
  wire logic [15:0] suspBit = 16'h0001 << udim_pkg::SUSP_BIT;
  // Next mode word: a bus write, then the hardware set or clear of the go-suspend bit on top.
  wire logic [15:0] modeBase = wrMode ? modeNew : mode_q;
  wire logic [15:0] modeNext = suspStop ? (modeBase | suspBit)
    : (wakeRead ? (modeBase & ~suspBit) : modeBase);
  // Read image of the mode register with the captured straps and the live bus power mirror.
  wire logic [15:0] modeRd = {strap_q, 3'b000, mode_q[udim_pkg::DMA_CLK_BIT], vbus_q, mode_q[7:0]}; // see RQ9
  wire logic [15:0] rdWord = (busReq.addr == udim_pkg::MODE_REG_OFS) ? modeRd : {8'h00, addr_q};
  // Byte reads on a 16-bit bus return the whole word; the processor ignores the upper lane.
  wire logic [15:0] rdLane = (!busWide16 && busReq.hiLane) ? {8'h00, rdWord[15:8]} : rdWord; // see RQ2

  // Sequencer next state: suspend entry, clock stop delay, resume wait and drive.
  always_comb
  begin
    pst_d = pst_q;
    cnt_d = cnt_q;
    case (pst_q)
      udim_pkg::PS_RUN:
      begin
        if (suspTrig)
        begin
          pst_d = udim_pkg::PS_SUSP_WAIT;
          cnt_d = '0;
        end
        else if (resumeTrig)
        begin
          pst_d = udim_pkg::PS_RES_WAIT;
          cnt_d = '0;
        end
      end
      udim_pkg::PS_SUSP_WAIT:
      begin
        // With clocks kept on, suspend is entered but the oscillator stays up.
        if (cnt_q == udim_pkg::CNT_W'(SUSP_CLK_CYCLES - 1))
          pst_d = udim_pkg::PS_SUSP; // see RQ12
        else
          cnt_d = cnt_q + 1'b1;
      end
      udim_pkg::PS_SUSP:
      begin
        if (wakeRead || resumeTrig)
        begin
          pst_d = resumeTrig ? udim_pkg::PS_RES_WAIT : udim_pkg::PS_RUN;
          cnt_d = '0;
        end
      end
      udim_pkg::PS_RES_WAIT:
      begin
        if (cnt_q == udim_pkg::CNT_W'(RESUME_WAIT_CYCLES - 1))
        begin
          pst_d = udim_pkg::PS_RES_DRIVE;
          cnt_d = '0;
        end
        else
          cnt_d = cnt_q + 1'b1;
      end
      udim_pkg::PS_RES_DRIVE:
      begin
        if (cnt_q == udim_pkg::CNT_W'(RESUME_LEN_CYCLES - 1))
          pst_d = udim_pkg::PS_RUN; // see RQ13
        else
          cnt_d = cnt_q + 1'b1;
      end
      default:
      begin
        pst_d = udim_pkg::PS_RUN;
        cnt_d = '0;
      end
    endcase
  end

  // Address register: reset clears it, bus reset clears the field and sets enable.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_q <= 8'h00;
      addrUse_q <= 8'h00;
      addrPend_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (softRst)
      begin
        addr_q <= 8'h00; // see RQ5
        addrUse_q <= 8'h00;
        addrPend_q <= 1'b0;
      end
      else if (usbBusReset)
      begin
        addr_q <= {1'b1, udim_pkg::ADDR_RESET}; // see RQ6
        addrUse_q <= {1'b1, udim_pkg::ADDR_RESET};
        addrPend_q <= 1'b0;
      end
      else if (wrAddr)
      begin
        // Firmware writes before sending the status stage, so matching keeps the old address.
        addr_q <= wrData[7:0]; // see RQ7
        addrPend_q <= 1'b1;
      end
      else if (addrPend_q && statusAcked)
      begin
        addrUse_q <= addr_q; // see RQ8
        addrPend_q <= 1'b0;
      end
    end
  end

  // Mode register storage; bus reset keeps the interrupt gate and pull-up bits.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mode_q <= udim_pkg::MODE_RESET;
    else if (clkEn)
    begin
      if (softRst)
        mode_q <= udim_pkg::MODE_RESET;
      else if (usbBusReset)
        mode_q <= mode_q & udim_pkg::MODE_BUSRST_KEEP; // see RQ19
      else
        mode_q <= modeNext; // see RQ12
    end
  end

  // Straps are taken once after reset release; bus power is followed every cycle.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_q <= 3'b000;
      strapDone_q <= 1'b0;
      vbus_q <= 1'b0;
    end
    else if (clkEn)
    begin
      vbus_q <= busPowerSense; // see RQ11
      if (!strapDone_q)
      begin
        strap_q <= {modeSelectPinB, modeSelectPinA, busConfigStrap}; // see RQ9
        strapDone_q <= 1'b1;
      end
    end
  end

  // Sequencer and wake pulse counter; soft reset returns to running.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pst_q <= udim_pkg::PS_RUN;
      cnt_q <= '0;
      pulse_q <= '0;
    end
    else if (clkEn)
    begin
      pst_q <= softRst ? udim_pkg::PS_RUN : pst_d;
      cnt_q <= softRst ? '0 : cnt_d;
      // A soft reset also cancels a wake pulse in flight, as a hardware reset would.
      if (softRst)
        pulse_q <= '0; // see RQ15
      else if (pst_q == udim_pkg::PS_SUSP && pst_d != udim_pkg::PS_SUSP)
        pulse_q <= udim_pkg::CNT_W'(WAKE_PULSE_CYCLES); // see RQ18
      else if (pulse_q != '0)
        pulse_q <= pulse_q - 1'b1;
    end
  end

  // Registered outputs.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdData <= 16'h0000;
      activeAddr <= 8'h00;
      deviceEnabled <= 1'b0;
      dmaClockGate <= 1'b0;
      oscRunning <= 1'b1;
      resumeDrive <= 1'b0;
      suspendPin <= 1'b0;
      pullupConnect <= 1'b0;
      irqOut <= 1'b0;
    end
    else if (clkEn)
    begin
      rdData <= busReq.rd ? rdLane : 16'h0000;
      activeAddr <= {1'b0, addrUse_q[6:0]};
      deviceEnabled <= addrUse_q[udim_pkg::DEV_EN_BIT];
      dmaClockGate <= mode_q[udim_pkg::DMA_CLK_BIT]; // see RQ10
      oscRunning <= (pst_q != udim_pkg::PS_SUSP) || mode_q[udim_pkg::CLK_ON_BIT]; // see RQ12
      resumeDrive <= (pst_q == udim_pkg::PS_RES_DRIVE);
      suspendPin <= mode_q[udim_pkg::PIN_STYLE_BIT] ? (pulse_q != '0) : inSusp; // see RQ18
      pullupConnect <= mode_q[udim_pkg::PULLUP_BIT]; // see RQ19
      irqOut <= irqPending && mode_q[udim_pkg::GIRQ_BIT]; // see RQ16
    end
  end
endmodule : udim_regs

/* File: udim_pkg.sv */
// Package with offsets, field positions, reset values and timing for the init/mode register bank.
package udim_pkg;
  // Register offsets on the parallel bus.
  localparam logic [7:0] ADDR_REG_OFS = 8'h00;
  localparam logic [7:0] MODE_REG_OFS = 8'h0C;
  // Address register fields.
  localparam int DEV_EN_BIT = 7;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  // Mode register fields.
  localparam int STRAP_HI_BIT = 15;
  localparam int STRAP_MID_BIT = 14;
  localparam int STRAP_LO_BIT = 13;
  localparam int DMA_CLK_BIT = 9;
  localparam int VBUS_BIT = 8;
  localparam int CLK_ON_BIT = 7;
  localparam int RESUME_BIT = 6;
  localparam int SUSP_BIT = 5;
  localparam int SRST_BIT = 4;
  localparam int GIRQ_BIT = 3;
  localparam int WAKE_RD_BIT = 2;
  localparam int PIN_STYLE_BIT = 1;
  localparam int PULLUP_BIT = 0;
  // Writable bits of the mode register; reserved bits 12..10 have no storage.
  localparam logic [15:0] MODE_WR_MASK = 16'h02FF;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  // Bits kept across a USB bus reset.
  localparam logic [15:0] MODE_BUSRST_KEEP = 16'h0009;
  // Timing figures in microseconds and clock rate in MHz.
  localparam int CLK_MHZ = 250;
  localparam int SUSP_CLK_US = 2000;
  localparam int RESUME_WAIT_US = 5000;
  localparam int RESUME_LEN_US = 10000;
  localparam int WAKE_PULSE_US = 1000;
  localparam int SUSP_CLK_CYC = SUSP_CLK_US * CLK_MHZ;
  localparam int RESUME_WAIT_CYC = RESUME_WAIT_US * CLK_MHZ;
  localparam int RESUME_LEN_CYC = RESUME_LEN_US * CLK_MHZ;
  localparam int WAKE_PULSE_CYC = WAKE_PULSE_US * CLK_MHZ;
  localparam int CNT_W = 22;

  // One bus access as seen by the bank.
  typedef struct packed {
    logic rd;
    logic wr;
    logic hiLane;
    logic [7:0] addr;
    logic [15:0] wdata;
  } udim_bus_t;

  // Power and resume sequencer states.
  typedef enum logic [2:0] {
    PS_RUN = 3'b000,
    PS_SUSP_WAIT = 3'b001,
    PS_SUSP = 3'b010,
    PS_RES_WAIT = 3'b011,
    PS_RES_DRIVE = 3'b100
  } udim_pstate_t;
endpackage : udim_pkg

/* File: udim_monitor.sv */
// Checker of port-level relations for the init and mode register bank.
`timescale 1ns/1ps
module udim_monitor #(
  parameter int RESUME_LEN_CYCLES = udim_pkg::RESUME_LEN_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic busWide16,
  input wire udim_pkg::udim_bus_t busReq,
  input wire logic [15:0] rdData,
  input wire logic usbBusReset,
  input wire logic irqPending,
  input wire logic [7:0] activeAddr,
  input wire logic deviceEnabled,
  input wire logic dmaClockGate,
  input wire logic oscRunning,
  input wire logic resumeDrive,
  input wire logic pullupConnect,
  input wire logic irqOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // A full-word mode write; its effect shows two cycles on.
  wire modeWr = busReq.wr && busWide16 && (busReq.addr == udim_pkg::MODE_REG_OFS);
  // A wide read of the mode word.
  wire modeRd = busReq.rd && busWide16 && (busReq.addr == udim_pkg::MODE_REG_OFS);
  // Expected length of one resume drive, at the counter's width.
  localparam logic [udim_pkg::CNT_W-1:0] RUN_END = udim_pkg::CNT_W'(RESUME_LEN_CYCLES);
  // Cycles of resume drive seen so far; a counter stands in for a repetition far too long to unroll.
  logic [udim_pkg::CNT_W-1:0] resumeRun;
  // Counts while the drive is high and restarts from zero once it drops.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      resumeRun <= '0;
    else if (resumeDrive)
      resumeRun <= resumeRun + 1'b1;
    else
      resumeRun <= '0;
  end
  a_irq_gated: assert property (!$past(irqPending) |-> !irqOut) else $error("irq out without pending");
  a_rsvd_zero: assert property (modeRd |=> rdData[12:10] == 3'h0) else $error("reserved bits read set");
  a_busrst_addr: assert property (usbBusReset |-> ##[1:2] deviceEnabled && activeAddr == 8'h00)
    else $error("bus reset address wrong");
  a_busrst_dma: assert property (usbBusReset |-> ##[1:2] !dmaClockGate) else $error("dma gate kept");
  a_pullup_wr: assert property (modeWr |-> ##2 pullupConnect == $past(busReq.wdata[0], 2))
    else $error("pullup not written");
  a_dma_wr: assert property (modeWr |-> ##2 dmaClockGate == $past(busReq.wdata[9], 2))
    else $error("dma gate not written");
  a_resume_len: assert property ($fell(resumeDrive) |-> resumeRun == RUN_END) else $error("resume too short");
  a_resume_max: assert property (resumeDrive |-> resumeRun < RUN_END) else $error("resume too long");
  a_osc_resume: assert property (!oscRunning |-> !resumeDrive) else $error("resume with clock off");
  // Main scenarios reached.
  c_resume: cover property ($rose(resumeDrive));
  c_suspend: cover property ($fell(oscRunning));
  c_irq: cover property ($rose(irqOut));
endmodule : udim_monitor

/* File: udim_host_model.sv */
// Host processor model that runs register cycles on the parallel bus.
`timescale 1ns/1ps
module udim_host_model (
  input wire logic clk,
  input wire logic [15:0] rdData,
  output udim_pkg::udim_bus_t busReq,
  output logic statusAcked
);
  // Bus idle at time zero; this host touches no per-endpoint register, so no index select is needed.
  initial
  begin
    busReq = '0;
    statusAcked = 1'b0;
  end
  // One write, launched and released on falling edges.
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic hi);
    @(negedge clk);
    busReq = '{rd: 1'b0, wr: 1'b1, hiLane: hi, addr: a, wdata: d};
    @(negedge clk);
    busReq = '0;
  endtask : wr
  // One read; a one-byte register drops the upper lane on the wide bus.
  task automatic rd(input logic [7:0] a, input logic hi, input logic oneByte, output logic [15:0] q);
    @(negedge clk);
    busReq = '{rd: 1'b1, wr: 1'b0, hiLane: hi, addr: a, wdata: 16'h0000};
    @(negedge clk);
    q = oneByte ? {8'h00, rdData[7:0]} : rdData;
    busReq = '0;
  endtask : rd
  // Host acknowledge of the empty status packet, sent after the address write.
  task automatic ack;
    @(negedge clk);
    statusAcked = 1'b1;
    @(negedge clk);
    statusAcked = 1'b0;
  endtask : ack
endmodule : udim_host_model

/* File: usb_device_init_mode_regs_tb.sv */
// Self-checking bench for the init and mode register bank.
`timescale 1ns/1ps
module usb_device_init_mode_regs_tb;
  localparam logic [7:0] AD = udim_pkg::ADDR_REG_OFS;
  localparam logic [7:0] MD = udim_pkg::MODE_REG_OFS;
  // Small timing values keep suspend and resume runs short.
  localparam int SUSP_C = 4;
  localparam int RES_W = 5;
  localparam int RES_L = 10;
  localparam int WAKE_P = 3;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic busWide16 = 1'b1;
  logic usbBusReset = 1'b0;
  logic irqPending = 1'b0;
  logic busPowerSense = 1'b0;
  logic [2:0] straps = 3'h0;
  udim_pkg::udim_bus_t busReq;
  logic statusAcked;
  logic [15:0] rdData;
  logic [15:0] q;
  logic [15:0] w;
  logic [7:0] activeAddr;
  logic deviceEnabled, dmaClockGate, oscRunning, resumeDrive, suspendPin, pullupConnect, irqOut;
  int err_total = 0;
  int cmp_count = 0;
  int n;
  always #2 clk = ~clk;
  udim_regs #(.SUSP_CLK_CYCLES(SUSP_C), .RESUME_WAIT_CYCLES(RES_W), .RESUME_LEN_CYCLES(RES_L),
    .WAKE_PULSE_CYCLES(WAKE_P))
    udim_regs_inst (.clk, .nrst, .clkEn(1'b1), .busWide16, .busReq, .rdData, .usbBusReset, .statusAcked,
    .irqPending, .modeSelectPinB(straps[2]), .modeSelectPinA(straps[1]), .busConfigStrap(straps[0]),
    .busPowerSense, .activeAddr, .deviceEnabled, .dmaClockGate, .oscRunning, .resumeDrive, .suspendPin,
    .pullupConnect, .irqOut);
  udim_host_model udim_host_model_inst (.clk, .rdData, .busReq, .statusAcked);
  // Expected mode word: straps on top, reserved zero, live power sense.
  function automatic logic [15:0] expMode(input logic [15:0] v);
    return {straps, 3'h0, v[9], busPowerSense, v[7:0]};
  endfunction : expMode
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // Watchdog well beyond the expected run of a few hundred cycles.
  initial
  begin
    #20000;
    err_total++;
    test_done();
  end
  // Main sequence.
  initial
  begin
    void'($urandom(32'hB535));
    straps = 3'($urandom);
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    udim_host_model_inst.rd(AD, 1'b0, 1'b1, q);
    chk("addr reset", 16'h0000, q);
    udim_host_model_inst.rd(MD, 1'b0, 1'b0, q);
    chk("mode reset", expMode(16'h0000), q);
    udim_host_model_inst.wr(AD, 16'h0085, 1'b0);
    repeat (3) @(negedge clk);
    chk("addr before ack", 16'h0000, {7'h00, deviceEnabled, activeAddr});
    udim_host_model_inst.ack();
    repeat (2) @(negedge clk);
    chk("addr after ack", 16'h0105, {7'h00, deviceEnabled, activeAddr});
    udim_host_model_inst.wr(MD, 16'h0209, 1'b0);
    usbBusReset = 1'b1;
    @(negedge clk);
    usbBusReset = 1'b0;
    repeat (2) @(negedge clk);
    udim_host_model_inst.rd(AD, 1'b0, 1'b1, q);
    chk("addr bus reset", 16'h0080, q);
    udim_host_model_inst.rd(MD, 1'b0, 1'b0, q);
    chk("mode bus reset", expMode(16'h0009), q);
    // Bytes on the narrow bus, low lane first.
    busWide16 = 1'b0;
    udim_host_model_inst.wr(MD, 16'h0006, 1'b0);
    udim_host_model_inst.wr(MD, 16'h0002, 1'b1);
    udim_host_model_inst.rd(MD, 1'b0, 1'b0, q);
    chk("mode lo byte", 16'h0006, {8'h00, q[7:0]});
    udim_host_model_inst.rd(MD, 1'b1, 1'b0, q);
    chk("mode hi byte", expMode(16'h0200) >> 8, {8'h00, q[7:0]});
    busWide16 = 1'b1;
    // Random words, trigger bits kept low, read-only and reserved bits set at times.
    for (n = 0; n < 40; n++)
    begin
      w = (n == 0) ? 16'hFF8F : 16'($urandom) & 16'hFF8F;
      busPowerSense = 1'($urandom);
      irqPending = 1'($urandom);
      udim_host_model_inst.wr(MD, w, 1'b0);
      udim_host_model_inst.rd(MD, 1'b0, 1'b0, q);
      chk("mode rand", expMode(w), q);
      chk("dma and pullup", {14'h0000, w[9], w[0]}, {14'h0000, dmaClockGate, pullupConnect});
      chk("irq gate", {15'h0000, irqPending & w[3]}, {15'h0000, irqOut});
    end
    udim_host_model_inst.wr(MD, 16'h0040, 1'b0);
    udim_host_model_inst.wr(MD, 16'h0000, 1'b0);
    for (n = 0; n < 20 && resumeDrive !== 1'b1; n++)
      @(negedge clk);
    chk("resume drive", 16'h0001, {15'h0000, resumeDrive});
    chk("resume wait", 16'(RES_W + 1), 16'(n));
    repeat (20) @(negedge clk);
    udim_host_model_inst.wr(MD, 16'h0024, 1'b0);
    udim_host_model_inst.wr(MD, 16'h0004, 1'b0);
    repeat (10) @(negedge clk);
    chk("suspended", 16'h0001, {14'h0000, oscRunning, suspendPin});
    udim_host_model_inst.rd(MD, 1'b0, 1'b0, q);
    chk("go suspend bit", expMode(16'h0024), q);
    repeat (10) @(negedge clk);
    chk("woken", 16'h0002, {14'h0000, oscRunning, suspendPin});
    // Pulse style: pin low in suspend, then one pulse of the wake length after the waking read.
    udim_host_model_inst.wr(MD, 16'h0026, 1'b0);
    udim_host_model_inst.wr(MD, 16'h0006, 1'b0);
    repeat (10) @(negedge clk);
    chk("pulse style suspended", 16'h0000, {14'h0000, oscRunning, suspendPin});
    udim_host_model_inst.rd(MD, 1'b0, 1'b0, q);
    w = 16'h0000;
    repeat (8)
    begin
      @(negedge clk);
      w = w + {15'h0000, suspendPin};
    end
    chk("wake pulse length", 16'(WAKE_P), w);
    udim_host_model_inst.wr(MD, 16'h0011, 1'b0);
    udim_host_model_inst.wr(MD, 16'h0000, 1'b0);
    repeat (3) @(negedge clk);
    udim_host_model_inst.rd(AD, 1'b0, 1'b1, q);
    chk("addr soft reset", 16'h0000, q);
    chk("enable soft reset", 16'h0000, {7'h00, deviceEnabled, activeAddr});
    test_done();
  end
endmodule : usb_device_init_mode_regs_tb
bind udim_regs udim_monitor #(.RESUME_LEN_CYCLES(RESUME_LEN_CYCLES)) udim_monitor_inst (.clk, .nrst, .busWide16,
  .busReq, .rdData, .usbBusReset,
  .irqPending, .activeAddr, .deviceEnabled, .dmaClockGate, .oscRunning, .resumeDrive, .pullupConnect, .irqOut);
